// ---- shared/board_ctrl_pkg.sv ----
// constants for the board control register bank
package board_ctrl_pkg;
	localparam logic [15:0] OFF_MCAST   = 16'hef0c;
	localparam logic [15:0] OFF_BASE_RELOCATION_ENABLE   = 16'hef10;
	localparam logic [15:0] OFF_IRQ_ID  = 16'hef14;
	localparam logic [15:0] OFF_IRQ_THR = 16'hef18;
	localparam logic [15:0] OFF_BLT_CNT = 16'hef1c;
	localparam logic [15:0] OFF_SCRATCH = 16'hef20;
	localparam logic [15:0] OFF_SRESET  = 16'hef24;
	localparam logic [15:0] OFF_SCLEAR  = 16'hef28;
	localparam logic [15:0] OFF_FGATE   = 16'hef2c;
	localparam logic [15:0] OFF_FDATA   = 16'hef30;
	// field positions
	localparam int MCAST_ADDR_LSB = 0;
	localparam int MCAST_ADDR_W   = 8;
	localparam int CHAIN_ROLE_LSB = 8;
	localparam int CHAIN_ROLE_W   = 2;
	localparam int BASE_RELOCATION_ENABLE_W        = 16;
	localparam int IRQ_THR_W      = 10;
	localparam int BLT_CNT_W      = 8;
	localparam int FDATA_W        = 8;
	localparam int FGATE_BIT      = 0;
	// reset values
	localparam logic [9:0]  MCAST_RST   = 10'h000;
	localparam logic [15:0] BASE_RELOCATION_ENABLE_RST   = 16'h0000;
	localparam logic [31:0] IRQ_ID_RST  = 32'h0000_0000;
	localparam logic [9:0]  IRQ_THR_RST = 10'h000;
	localparam logic [7:0]  BLT_CNT_RST = 8'h00;
	localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
	localparam logic        FGATE_RST   = 1'b1;
	localparam logic [7:0]  FDATA_RST   = 8'h00;
	// chain roles
	localparam logic [1:0] ROLE_OFF = 2'h0;
	localparam logic [1:0] ROLE_LAST = 2'h1;
	localparam logic [1:0] ROLE_FIRST = 2'h2;
	localparam logic [1:0] ROLE_MID = 2'h3;
	// timing: flash serial clock half period, least time
	localparam int CLK_PERIOD_NS  = 5;
	localparam int SPI_HALF_NS    = 20;
	localparam int SPI_HALF_CYC   = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- verilog/flash_byte_shifter.sv ----
// serialiser that sends one byte msb first to the firmware flash
`timescale 1ns/10ps
module flash_byte_shifter #(
	parameter int HALF_CYC = board_ctrl_pkg::SPI_HALF_CYC
) (
	input  wire logic       clk,    // board clock
	input  wire logic       rst,    // sync reset, active high
	input  wire logic       ce,     // clock enable
	input  wire logic       start,  // one-cycle load request
	input  wire logic [7:0] data,   // byte to send
	output logic            busy,   // transfer in progress
	output logic            sclk,   // serial clock to flash
	output logic            mosi,   // serial data to flash
	output logic            cs_n    // flash select, active low
);
	typedef enum logic {sh_idle, sh_run} sh_state_t;
	sh_state_t   st_q, st_d;
	logic [7:0]  sh_q, sh_d;
	logic [2:0]  bit_q, bit_d;
	logic [7:0]  hc_q, hc_d;
	logic        sclk_q, sclk_d;
	logic        cs_n_q, cs_n_d;

	assign busy = (st_q == sh_run);
	assign sclk = sclk_q;
	assign mosi = sh_q[7];
	assign cs_n = cs_n_q;

	// mode 0: data set while sclk low, flash samples on the rising edge
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bit_d = bit_q;
		hc_d = hc_q;
		sclk_d = sclk_q;
		cs_n_d = cs_n_q;
		unique case (st_q)
			sh_idle: begin
				if (start) begin
					st_d = sh_run;
					sh_d = data;
					bit_d = 3'h0;
					hc_d = 8'h00;
					cs_n_d = 1'b0;
				end
			end
			sh_run: begin
				if (hc_q == 8'(HALF_CYC - 1)) begin
					hc_d = 8'h00;
					sclk_d = ~sclk_q;
					if (sclk_q) begin
						if (bit_q == 3'h7) begin
							st_d = sh_idle;
							cs_n_d = 1'b1;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							bit_d = bit_q + 3'h1;
						end
					end
				end else begin
					hc_d = hc_q + 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= sh_idle;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			hc_q <= 8'h00;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			hc_q <= hc_d;
			sclk_q <= sclk_d;
			cs_n_q <= cs_n_d;
		end
	end

	// eight rising edges per byte, select held low throughout
	flash_sel_a: assert property (@(posedge clk) disable iff (rst)
		(ce && start && !busy) |=> !cs_n_q) else $error("flash select not asserted on start");
endmodule

// ---- verilog/board_control_regs.sv ----
// board control register bank: addressing, interrupt, scratch, strobes, flash port, loader
`timescale 1ns/10ps
module board_control_regs #(
	parameter int ROT_W = 16
) (
	input  wire logic              clk,          // 200 MHz board clock
	input  wire logic              rst,          // power-on reset, sync, active high
	input  wire logic              ce,           // clock enable
	input  wire logic [15:0]       bus_addr,     // register offset
	input  wire logic              bus_wr,       // write strobe, one cycle
	input  wire logic              bus_rd,       // read strobe, one cycle
	input  wire logic [31:0]       bus_wdata,    // write data
	input  wire logic              iack,         // interrupt acknowledge strobe
	input  wire logic [2:0]        iack_level,   // line being acknowledged
	output logic [31:0]            bus_rdata,    // read or status/id data
	output logic                   bus_ack,      // answer pulse
	input  wire logic [ROT_W-1:0]  rotary_base,  // rotary switch pins
	input  wire logic              base_relocation_enable, // 1 uses relocation register
	input  wire logic [2:0]        irq_level,    // 0 disables interrupts
	input  wire logic [9:0]        events_stored,// events in output buffer
	input  wire logic              xfer_start,   // block transfer begins
	input  wire logic              xfer_event,   // one event sent
	output logic [15:0]            base_addr,    // active base A31..A16
	output logic [7:0]             multicast_cycle_addr, // multicast upper address
	output logic [1:0]             chain_role,   // daisy chain role
	output logic                   xfer_stop,    // transfer reached its event count
	output logic                   irq_req,      // interrupt request
	output logic [2:0]             irq_line,     // line requested
	output logic                   soft_reset,   // module reset pulse
	output logic                   mem_clear,    // event memory clear
	output logic                   flash_sclk,   // flash serial clock
	output logic                   flash_mosi,   // flash serial data
	output logic                   flash_cs_n,   // flash select, active low
	input  wire logic              image_select_jumper, // jumper pin: 0 standard, 1 backup
	input  wire logic              cfg_done,     // configuration engine finished
	output logic                   cfg_start,    // load request pulse
	output logic                   cfg_backup_image, // 1 loads backup_image
	output logic                   cfg_ready     // logic configured
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [ROT_W-1:0] rot_m_q, rot_s_q;
	logic             jmp_m_q, jmp_s_q;
	always_ff @(posedge clk) begin
		if (ce) begin
			rot_m_q <= rotary_base;
			rot_s_q <= rot_m_q;
			jmp_m_q <= image_select_jumper;
			jmp_s_q <= jmp_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register bank
	logic [9:0]  mc_q, mc_d;
	logic [15:0] base_relocation_enable_q, base_relocation_enable_d;
	logic [31:0] irq_id_q, irq_id_d;
	logic [9:0]  irq_thr_q, irq_thr_d;
	logic [7:0]  blt_q, blt_d;
	logic [31:0] scratch_q, scratch_d;
	logic        fgate_q, fgate_d;
	logic [7:0]  fdata_q, fdata_d;
	logic [31:0] rdata_q, rdata_d;
	logic        ack_q, ack_d;
	logic        srst_q, srst_d;
	logic        clr_q, clr_d;
	logic [15:0] base_q, base_d;
	logic        reg_rst;
	logic        spi_start;
	logic        spi_busy;
	logic        iack_hit;
	logic        irq_req_q, irq_req_d;
	logic [2:0]  irq_line_q, irq_line_d;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	// soft reset reuses the power-on path so both give the same defaults
	assign reg_rst = rst || srst_q;
	assign iack_hit = iack && irq_req_q && (iack_level == irq_line_q);

	// decode, write and read mux
	always_comb begin
		mc_d = mc_q;
		base_relocation_enable_d = base_relocation_enable_q;
		irq_id_d = irq_id_q;
		irq_thr_d = irq_thr_q;
		blt_d = blt_q;
		scratch_d = scratch_q;
		fgate_d = fgate_q;
		fdata_d = fdata_q;
		spi_start = 1'b0;
		srst_d = 1'b0;
		clr_d = 1'b0;
		ack_d = 1'b0;
		rdata_d = rdata_q;
		if (bus_wr) begin
			ack_d = 1'b1;
			if (hit(bus_addr, board_ctrl_pkg::OFF_MCAST))
				mc_d = bus_wdata[9:0];
			if (hit(bus_addr, board_ctrl_pkg::OFF_BASE_RELOCATION_ENABLE))
				base_relocation_enable_d = bus_wdata[15:0];
			if (hit(bus_addr, board_ctrl_pkg::OFF_IRQ_ID))
				irq_id_d = bus_wdata;
			if (hit(bus_addr, board_ctrl_pkg::OFF_IRQ_THR))
				irq_thr_d = bus_wdata[9:0];
			if (hit(bus_addr, board_ctrl_pkg::OFF_BLT_CNT))
				blt_d = bus_wdata[7:0];
			if (hit(bus_addr, board_ctrl_pkg::OFF_SCRATCH))
				scratch_d = bus_wdata;
			if (hit(bus_addr, board_ctrl_pkg::OFF_SRESET))
				srst_d = 1'b1;
			if (hit(bus_addr, board_ctrl_pkg::OFF_SCLEAR))
				clr_d = 1'b1;
			if (hit(bus_addr, board_ctrl_pkg::OFF_FGATE))
				fgate_d = bus_wdata[board_ctrl_pkg::FGATE_BIT];
			// blocked while gated or while the previous byte is still going out
			if (hit(bus_addr, board_ctrl_pkg::OFF_FDATA) && !fgate_q && !spi_busy) begin
				fdata_d = bus_wdata[7:0];
				spi_start = 1'b1;
			end
		end else if (bus_rd) begin
			ack_d = 1'b1;
			rdata_d = 32'h0000_0000; // unmapped and strobe offsets read zero
			unique case (bus_addr)
				board_ctrl_pkg::OFF_MCAST:   rdata_d = {22'h0, mc_q};
				board_ctrl_pkg::OFF_BASE_RELOCATION_ENABLE:   rdata_d = {16'h0, base_relocation_enable_q};
				board_ctrl_pkg::OFF_IRQ_ID:  rdata_d = irq_id_q;
				board_ctrl_pkg::OFF_IRQ_THR: rdata_d = {22'h0, irq_thr_q};
				board_ctrl_pkg::OFF_BLT_CNT: rdata_d = {24'h0, blt_q};
				board_ctrl_pkg::OFF_SCRATCH: rdata_d = scratch_q;
				board_ctrl_pkg::OFF_FGATE:   rdata_d = {31'h0, fgate_q};
				board_ctrl_pkg::OFF_FDATA:   rdata_d = {24'h0, fdata_q};
				default:                     rdata_d = 32'h0000_0000;
			endcase
		end else if (iack_hit) begin
			ack_d = 1'b1;
			rdata_d = irq_id_q;
		end
	end

	// relocation source picks the active base address
	always_comb begin
		base_d = base_relocation_enable ? base_relocation_enable_q : rot_s_q[15:0];
	end

	always_ff @(posedge clk) begin
		if (reg_rst) begin
			mc_q <= board_ctrl_pkg::MCAST_RST;
			base_relocation_enable_q <= board_ctrl_pkg::BASE_RELOCATION_ENABLE_RST;
			irq_id_q <= board_ctrl_pkg::IRQ_ID_RST;
			irq_thr_q <= board_ctrl_pkg::IRQ_THR_RST;
			blt_q <= board_ctrl_pkg::BLT_CNT_RST;
			scratch_q <= board_ctrl_pkg::SCRATCH_RST;
			fgate_q <= board_ctrl_pkg::FGATE_RST;
			fdata_q <= board_ctrl_pkg::FDATA_RST;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			srst_q <= 1'b0;
			clr_q <= 1'b1; // buffer emptied while held in reset
			base_q <= 16'h0000;
		end else if (ce) begin
			mc_q <= mc_d;
			base_relocation_enable_q <= base_relocation_enable_d;
			irq_id_q <= irq_id_d;
			irq_thr_q <= irq_thr_d;
			blt_q <= blt_d;
			scratch_q <= scratch_d;
			fgate_q <= fgate_d;
			fdata_q <= fdata_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			srst_q <= srst_d;
			clr_q <= clr_d;
			base_q <= base_d;
		end
	end

	assign bus_rdata = rdata_q;
	assign bus_ack = ack_q;
	assign base_addr = base_q;
	assign multicast_cycle_addr = mc_q[7:0];
	assign chain_role = mc_q[9:8];
	assign soft_reset = srst_q;
	assign mem_clear = clr_q;

	////////////////////////////////////////////////////////////////////////////
	// interrupt request
	logic       acked_q, acked_d;
	logic       over;
	assign over = events_stored > irq_thr_q;
	// an acknowledged request stays down until the count falls back
	always_comb begin
		acked_d = acked_q;
		if (!over)
			acked_d = 1'b0;
		else if (iack_hit)
			acked_d = 1'b1;
		irq_req_d = (irq_level != 3'h0) && over && !acked_d;
		irq_line_d = irq_level;
	end
	always_ff @(posedge clk) begin
		if (reg_rst) begin
			irq_req_q <= 1'b0;
			irq_line_q <= 3'h0;
			acked_q <= 1'b0;
		end else if (ce) begin
			irq_req_q <= irq_req_d;
			irq_line_q <= irq_line_d;
			acked_q <= acked_d;
		end
	end
	assign irq_req = irq_req_q;
	assign irq_line = irq_line_q;

	////////////////////////////////////////////////////////////////////////////
	// per-transfer event limit; zero means no limit
	logic [7:0] xcnt_q, xcnt_d;
	logic       xstop_q, xstop_d;
	always_comb begin
		xcnt_d = xcnt_q;
		if (xfer_start)
			xcnt_d = 8'h00;
		else if (xfer_event && !xstop_q)
			xcnt_d = xcnt_q + 8'h01;
		xstop_d = (blt_q != 8'h00) && (xcnt_d >= blt_q);
	end
	always_ff @(posedge clk) begin
		if (reg_rst) begin
			xcnt_q <= 8'h00;
			xstop_q <= 1'b0;
		end else if (ce) begin
			xcnt_q <= xcnt_d;
			xstop_q <= xstop_d;
		end
	end
	assign xfer_stop = xstop_q;

	////////////////////////////////////////////////////////////////////////////
	// image loader; only power-on runs it, soft reset keeps the loaded image
	typedef enum logic [1:0] {ld_start, ld_wait, ld_done} ld_state_t;
	ld_state_t ld_q, ld_d;
	logic      cst_q, cst_d;
	logic      cimg_q, cimg_d;
	logic      crdy_q, crdy_d;
	logic [1:0] settle_q, settle_d;
	always_comb begin
		ld_d = ld_q;
		cst_d = 1'b0;
		cimg_d = cimg_q;
		crdy_d = crdy_q;
		settle_d = settle_q;
		unique case (ld_q)
			ld_start: begin
				// wait for the jumper to pass the synchroniser
				if (settle_q == 2'h3) begin
					cimg_d = jmp_s_q;
					cst_d = 1'b1;
					ld_d = ld_wait;
				end else begin
					settle_d = settle_q + 2'h1;
				end
			end
			ld_wait: begin
				if (cfg_done) begin
					crdy_d = 1'b1;
					ld_d = ld_done;
				end
			end
			ld_done: ;
			default: ld_d = ld_start;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			ld_q <= ld_start;
			cst_q <= 1'b0;
			cimg_q <= 1'b0;
			crdy_q <= 1'b0;
			settle_q <= 2'h0;
		end else if (ce) begin
			ld_q <= ld_d;
			cst_q <= cst_d;
			cimg_q <= cimg_d;
			crdy_q <= crdy_d;
			settle_q <= settle_d;
		end
	end
	assign cfg_start = cst_q;
	assign cfg_backup_image = cimg_q;
	assign cfg_ready = crdy_q;

	////////////////////////////////////////////////////////////////////////////
	// flash serial port
	flash_byte_shifter #(
		.HALF_CYC (board_ctrl_pkg::SPI_HALF_CYC)
	) u_flash (
		.clk   (clk),
		.rst   (reg_rst),
		.ce    (ce),
		.start (spi_start),
		.data  (bus_wdata[7:0]),
		.busy  (spi_busy),
		.sclk  (flash_sclk),
		.mosi  (flash_mosi),
		.cs_n  (flash_cs_n)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence wr_at(logic [15:0] off);
		ce && bus_wr && bus_addr == off;
	endsequence
	sequence rd_at(logic [15:0] off);
		ce && bus_rd && !bus_wr && bus_addr == off;
	endsequence

	scratch_readback_a: assert property (@(posedge clk) disable iff (reg_rst)
		wr_at(board_ctrl_pkg::OFF_SCRATCH) ##1 rd_at(board_ctrl_pkg::OFF_SCRATCH)
		|=> bus_ack && bus_rdata == $past(bus_wdata, 2)) else $error("scratch readback mismatch");
	soft_reset_defaults_a: assert property (@(posedge clk) disable iff (rst)
		wr_at(board_ctrl_pkg::OFF_SRESET) |=> soft_reset ##1 (scratch_q == board_ctrl_pkg::SCRATCH_RST
		&& mc_q == board_ctrl_pkg::MCAST_RST && fgate_q == board_ctrl_pkg::FGATE_RST))
		else $error("soft reset did not restore defaults");
	clear_keeps_cfg_a: assert property (@(posedge clk) disable iff (reg_rst)
		wr_at(board_ctrl_pkg::OFF_SCLEAR) |=> mem_clear && $stable(scratch_q) && $stable(irq_thr_q))
		else $error("clear pulse missing or config changed");
	flash_gate_a: assert property (@(posedge clk) disable iff (reg_rst)
		(wr_at(board_ctrl_pkg::OFF_FDATA) ##0 fgate_q) |=> $stable(fdata_q) && !spi_busy)
		else $error("flash write passed a closed gate");
	iack_id_a: assert property (@(posedge clk) disable iff (reg_rst)
		(ce && iack_hit && !bus_wr && !bus_rd) |=> bus_ack && bus_rdata == irq_id_q)
		else $error("wrong status id on acknowledge");
	irq_cause_a: assert property (@(posedge clk) disable iff (reg_rst)
		irq_req_q |-> $past(events_stored) > $past(irq_thr_q)) else $error("request without threshold crossing");
	irq_level_off_a: assert property (@(posedge clk) disable iff (reg_rst)
		(ce && irq_level == 3'h0) |=> !irq_req_q) else $error("request while level zero");
	irq_withdraw_a: assert property (@(posedge clk) disable iff (reg_rst)
		(ce && iack_hit) |=> !irq_req_q [*2]) else $error("request not withdrawn after acknowledge");
	base_select_a: assert property (@(posedge clk) disable iff (reg_rst)
		(ce && base_relocation_enable) |=> base_addr == $past(base_relocation_enable_q))
		else $error("relocated base not applied");
endmodule

// ---- dv/flash_rx_model.sv ----
// flash receiver model: collects whole bytes shifted in over the serial link
`timescale 1ns/10ps
module flash_rx_model (
	input  wire logic       sclk,     // serial clock from the block
	input  wire logic       mosi,     // serial data from the block
	input  wire logic       cs_n,     // select, active low
	output logic [7:0]      rx_byte,  // last whole byte received
	output int              rx_count  // whole bytes received
);
	logic [7:0] sh_q;
	int         bits_q;
	initial begin
		rx_byte = 8'h00;
		rx_count = 0;
		sh_q = 8'h00;
		bits_q = 0;
	end
	// mode 0: data taken on the rising serial clock, msb first
	always @(posedge sclk) begin
		if (!cs_n) begin
			sh_q = {sh_q[6:0], mosi};
			bits_q++;
		end
	end
	// a frame counts only with exactly eight bits, so short or long frames show up
	always @(posedge cs_n) begin
		if (bits_q == 8) begin
			rx_byte = sh_q;
			rx_count++;
		end
		bits_q = 0;
	end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the board control register bank
`timescale 1ns/10ps
module tb;
	logic        clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, iack = 1'b0;
	logic        base_relocation_enable_en = 1'b0, xfer_start = 1'b0, xfer_event = 1'b0, jumper = 1'b1, cfg_done = 1'b0;
	logic        ce = 1'b1;
	logic [15:0] bus_addr = 16'h0000, rotary = 16'h00c3;
	logic [31:0] bus_wdata = 32'h0000_0000, rv;
	logic [2:0]  iack_level = 3'h0, irq_level = 3'h0;
	logic [9:0]  events = 10'h000;
	logic [31:0] bus_rdata;
	logic [15:0] base_addr;
	logic [7:0]  mc_addr, rx_byte;
	logic [1:0]  chain_role;
	logic [2:0]  irq_line;
	logic        bus_ack, xfer_stop, irq_req, soft_reset, mem_clear, sclk, mosi, cs_n;
	logic        cfg_start, cfg_backup, cfg_ready;
	int          fails = 0, checks_done = 0, cyc = 0, rx_count, n_rst = 0, n_clr = 0, i;

	board_control_regs u_dut (.clk(clk), .rst(rst), .ce(ce), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .iack(iack), .iack_level(iack_level), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .rotary_base(rotary), .base_relocation_enable(base_relocation_enable_en), .irq_level(irq_level),
		.events_stored(events), .xfer_start(xfer_start), .xfer_event(xfer_event), .base_addr(base_addr),
		.multicast_cycle_addr(mc_addr), .chain_role(chain_role), .xfer_stop(xfer_stop), .irq_req(irq_req),
		.irq_line(irq_line), .soft_reset(soft_reset), .mem_clear(mem_clear), .flash_sclk(sclk),
		.flash_mosi(mosi), .flash_cs_n(cs_n), .image_select_jumper(jumper), .cfg_done(cfg_done),
		.cfg_start(cfg_start), .cfg_backup_image(cfg_backup), .cfg_ready(cfg_ready));
	flash_rx_model u_flash (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .rx_byte(rx_byte), .rx_count(rx_count));

	always #2.5 clk = ~clk;
	// strobe pulses counted at the falling edge, in the middle of their single cycle
	always @(negedge clk) begin
		cyc++;
		if (soft_reset === 1'b1) n_rst++;
		if (mem_clear === 1'b1 && !rst) n_clr++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one strobe cycle, answer looked at in its single cycle
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(negedge clk);
		bus_wr = wr;
		bus_rd = ~wr;
		bus_addr = a;
		bus_wdata = d;
		@(negedge clk);
		chk({31'h0, bus_ack}, 32'h1);
		rv = bus_rdata;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rv, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		for (i = 0; i < 10; i++)
			rdc(16'hef0c + 16'(4 * i), (i == 8) ? 32'h1 : 32'h0);
		rdc(16'hef34, 32'h0);
	endtask
	task automatic t_scratch();
		bus(1'b1, board_ctrl_pkg::OFF_SCRATCH, 32'ha5c3_0ff1);
		rdc(board_ctrl_pkg::OFF_SCRATCH, 32'ha5c3_0ff1);
		// write then read on consecutive edges, the read must already see the new word
		@(negedge clk);
		bus_wr = 1'b1;
		bus_addr = board_ctrl_pkg::OFF_SCRATCH;
		bus_wdata = 32'h5a3c_f00e;
		@(negedge clk);
		chk({31'h0, bus_ack}, 32'h1);
		bus_wr = 1'b0;
		bus_rd = 1'b1;
		@(negedge clk);
		chk({31'h0, bus_ack}, 32'h1);
		chk(bus_rdata, 32'h5a3c_f00e);
		bus_rd = 1'b0;
	endtask
	// frozen clock enable: a write must neither land nor be answered
	task automatic t_freeze();
		@(negedge clk);
		ce = 1'b0;
		bus_wr = 1'b1;
		bus_addr = board_ctrl_pkg::OFF_SCRATCH;
		bus_wdata = 32'h0bad_f00d;
		@(negedge clk);
		chk({31'h0, bus_ack}, 32'h0);
		bus_wr = 1'b0;
		ce = 1'b1;
		rdc(board_ctrl_pkg::OFF_SCRATCH, 32'h0);
	endtask
	// every chain role, upper bits written as ones must read back zero
	task automatic t_chain();
		for (i = 0; i < 4; i++) begin
			bus(1'b1, board_ctrl_pkg::OFF_MCAST, {22'h3f_ffff, 2'(i), 8'(8'ha0 + i)});
			chk({24'h0, mc_addr}, 32'(8'ha0 + i));
			chk({30'h0, chain_role}, 32'(i));
			rdc(board_ctrl_pkg::OFF_MCAST, {22'h0, 2'(i), 8'(8'ha0 + i)});
		end
	endtask
	task automatic t_base_relocation_enable();
		bus(1'b1, board_ctrl_pkg::OFF_BASE_RELOCATION_ENABLE, 32'habcd_1234);
		rdc(board_ctrl_pkg::OFF_BASE_RELOCATION_ENABLE, 32'h0000_1234);
		base_relocation_enable_en = 1'b1;
		idle(4);
		chk({16'h0, base_addr}, 32'h1234);
		base_relocation_enable_en = 1'b0;
		idle(4);
		chk({16'h0, base_addr}, 32'h00c3);
	endtask
	// threshold boundary, refused and matching acknowledge, re-raise, level zero
	task automatic t_irq();
		bus(1'b1, board_ctrl_pkg::OFF_IRQ_ID, 32'hcafe_0042);
		bus(1'b1, board_ctrl_pkg::OFF_IRQ_THR, 32'h0000_0005);
		irq_level = 3'h3;
		events = 10'd5;
		idle(3);
		chk({31'h0, irq_req}, 32'h0);
		events = 10'd6;
		idle(3);
		chk({31'h0, irq_req}, 32'h1);
		chk({29'h0, irq_line}, 32'h3);
		for (i = 2; i < 4; i++) begin
			iack_level = 3'(i);
			iack = 1'b1;
			idle(1);
			chk({31'h0, bus_ack}, (i == 3) ? 32'h1 : 32'h0);
			iack = 1'b0;
			idle(1);
		end
		chk(bus_rdata, 32'hcafe_0042);
		chk({31'h0, irq_req}, 32'h0);
		idle(3);
		chk({31'h0, irq_req}, 32'h0);
		events = 10'd5;
		idle(3);
		events = 10'd6;
		idle(3);
		chk({31'h0, irq_req}, 32'h1);
		events = 10'd5;
		idle(3);
		chk({31'h0, irq_req}, 32'h0);
		events = 10'd6;
		irq_level = 3'h0;
		idle(3);
		chk({31'h0, irq_req}, 32'h0);
		events = 10'd0;
	endtask
	task automatic t_blt();
		bus(1'b1, board_ctrl_pkg::OFF_BLT_CNT, 32'hffff_ff03);
		rdc(board_ctrl_pkg::OFF_BLT_CNT, 32'h3);
		xfer_start = 1'b1;
		idle(1);
		xfer_start = 1'b0;
		for (i = 0; i < 3; i++) begin
			idle(1);
			chk({31'h0, xfer_stop}, 32'h0);
			xfer_event = 1'b1;
			idle(1);
			xfer_event = 1'b0;
		end
		idle(1);
		chk({31'h0, xfer_stop}, 32'h1);
		xfer_start = 1'b1;
		idle(1);
		xfer_start = 1'b0;
		idle(1);
		chk({31'h0, xfer_stop}, 32'h0);
	endtask
	// gate still closed after reset, so the first byte must never reach the flash
	task automatic t_flash();
		bus(1'b1, board_ctrl_pkg::OFF_FDATA, 32'h0000_003c);
		idle(80);
		chk(32'(rx_count), 32'h0);
		bus(1'b1, board_ctrl_pkg::OFF_FGATE, 32'h0000_0000);
		rdc(board_ctrl_pkg::OFF_FGATE, 32'h0);
		bus(1'b1, board_ctrl_pkg::OFF_FDATA, 32'hffff_ffa5);
		for (i = 0; i < 200 && rx_count == 0; i++)
			idle(1);
		chk(32'(rx_count), 32'h1);
		chk({24'h0, rx_byte}, 32'ha5);
	endtask
	// pulse counts taken relative to a snapshot, so the reset-release pulse is not counted
	task automatic t_strobes();
		int clr0;
		int rst0;
		bus(1'b1, board_ctrl_pkg::OFF_SCRATCH, 32'h1357_9bdf);
		clr0 = n_clr;
		bus(1'b1, board_ctrl_pkg::OFF_SCLEAR, 32'h0000_0000);
		idle(1);
		chk(32'(n_clr - clr0), 32'h1);
		rdc(board_ctrl_pkg::OFF_SCRATCH, 32'h1357_9bdf);
		rst0 = n_rst;
		bus(1'b1, board_ctrl_pkg::OFF_SRESET, 32'h0000_0000);
		idle(3);
		chk(32'(n_rst - rst0), 32'h1);
		rdc(board_ctrl_pkg::OFF_SCRATCH, 32'h0);
		rdc(board_ctrl_pkg::OFF_FGATE, 32'h1);
		rdc(board_ctrl_pkg::OFF_MCAST, 32'h0);
		rdc(board_ctrl_pkg::OFF_SRESET, 32'h0);
		chk({24'h0, mc_addr}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		idle(10);
		chk({31'h0, mem_clear}, 32'h1);
		rst = 1'b0;
		for (i = 0; i < 20 && cfg_start !== 1'b1; i++)
			idle(1);
		chk({31'h0, cfg_start}, 32'h1);
		chk({31'h0, cfg_backup}, 32'h1);
		cfg_done = 1'b1;
		idle(1);
		cfg_done = 1'b0;
		idle(2);
		chk({31'h0, cfg_ready}, 32'h1);
		t_defaults();
		t_scratch();
		t_chain();
		t_base_relocation_enable();
		t_irq();
		t_blt();
		t_flash();
		t_strobes();
		t_freeze();
		end_of_test();
	end
endmodule
